// [hw/jbsp_defs.svh]
// Constants of the boundary-scan and programming port
`ifndef JBSP_DEFS_SVH
`define JBSP_DEFS_SVH
`define JBSP_NIO 32
`define JBSP_NDIN 4
`define JBSP_NMC 32
`define JBSP_IR_LEN 4
`define JBSP_IR_EXTEST 4'h0
`define JBSP_IR_SAMPLE 4'h1
`define JBSP_IR_IDCODE 4'h2
`define JBSP_IR_HIGHZ 4'h3
`define JBSP_IR_BYPASS 4'hf
`define JBSP_IR_CAPT 4'h1
// Arbitrary identification value, bit 0 set as the scan standard requires
`define JBSP_IDCODE 32'h0a5a_5001
`define JBSP_CAP_IO 3
`define JBSP_UPD_IO 2
`define JBSP_CAP_IN 1
`define JBSP_CAP_MC 1
`endif

// [hw/jbsp_pkg.sv]
// Types of the boundary-scan and programming port
package jbsp_pkg;
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } jbsp_tap_e;
   typedef enum logic [1:0] {
      CFG_ERASED, CFG_PROG, CFG_VALID, CFG_LOCKED
   } jbsp_cfg_e;
   typedef logic [3:0] jbsp_ir_t;
endpackage : jbsp_pkg

// [hw/jbsp_scan_cell.sv]
// One scan cell: capture/shift stages and optional update stages
`timescale 1ns/1ns
module jbsp_scan_cell #(
   parameter int NCAP = 3,
   parameter int NUPD = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic capture,
   input wire logic shift,
   input wire logic update,
   input wire logic [2:0] par_in,
   input wire logic si,
   output logic so,
   output logic [1:0] upd_out
);
   logic [2:0] cap_q;
   logic [1:0] upd_q;

   // Capture live signals, else shift toward so
   always_ff @(posedge clk)
   begin
      if (rst)
         cap_q <= 3'h0;
      else if (capture)
         cap_q <= par_in;
      else if (shift)
         cap_q <= {cap_q[1:0], si};
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         upd_q <= 2'h0;
      else if (update)
      begin
         for (int i = 0; i < NUPD; i++)
            upd_q[i] <= cap_q[i + NCAP - NUPD];
      end
   end

   assign so = cap_q[NCAP-1];
   assign upd_out = upd_q;
endmodule : jbsp_scan_cell

// [hw/jbsp_top.sv]
// Boundary-scan test access port with programming protection of the pins
`timescale 1ns/1ns
`include "jbsp_defs.svh"
module jbsp_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic TCK_I,
   input wire logic TMS_I,
   input wire logic TDI_I,
   input wire logic JTAG_EN,
   input wire logic PULLUP_EN,
   input wire logic KEEPER_EN,
   input wire logic PROG_START,
   input wire logic PROG_DONE,
   input wire logic PROG_ABORT,
   input wire logic [`JBSP_NIO-1:0] PIN_I,
   input wire logic [`JBSP_NDIN-1:0] DIN_I,
   input wire logic [`JBSP_NIO-1:0] CORE_O,
   input wire logic [`JBSP_NIO-1:0] CORE_OE,
   input wire logic [`JBSP_NMC-1:0] MC_I,
   input wire logic [3:0] USR_JPIN_O,
   input wire logic [3:0] USR_JPIN_OE,
   output logic [`JBSP_NIO-1:0] PIN_O,
   output logic [`JBSP_NIO-1:0] PIN_OE,
   output logic [3:0] JPIN_O,
   output logic [3:0] JPIN_OE,
   output logic PULLUP_ON,
   output logic CFG_VALID
);
   localparam int NCH = `JBSP_NIO + `JBSP_NDIN + `JBSP_NMC;

   // ****************************************
   // Synchronisers and test clock edges
   // ****************************************
   logic [2:0] tck_s_q;
   logic [1:0] tms_s_q;
   logic [1:0] tdi_s_q;
   logic [`JBSP_NIO-1:0] pin_s1_q, pin_s2_q;
   logic [`JBSP_NDIN-1:0] din_s1_q, din_s2_q;
   logic tck_rise, tck_fall, tms, tdi;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         tck_s_q <= 3'h0;
         tms_s_q <= 2'h3;
         tdi_s_q <= 2'h3;
      end
      else
      begin
         tck_s_q <= {tck_s_q[1:0], TCK_I};
         tms_s_q <= {tms_s_q[0], TMS_I};
         tdi_s_q <= {tdi_s_q[0], TDI_I};
      end
   end

   always_ff @(posedge CLK)
   begin
      pin_s1_q <= PIN_I;
      pin_s2_q <= pin_s1_q;
      din_s1_q <= DIN_I;
      din_s2_q <= din_s1_q;
   end

   assign tck_rise = tck_s_q[1] & ~tck_s_q[2];
   assign tck_fall = ~tck_s_q[1] & tck_s_q[2];
   assign tms = tms_s_q[1];
   assign tdi = tdi_s_q[1];

   logic jtag_en_q;
   always_ff @(posedge CLK)
   begin
      if (RST)
         jtag_en_q <= 1'b0;
      else
         jtag_en_q <= JTAG_EN;
   end

   // ****************************************
   // TAP state machine
   // ****************************************
   jbsp_pkg::jbsp_tap_e tap_q, tap_d;

   always_comb
   begin
      case (tap_q)
         jbsp_pkg::TLR: tap_d = tms ? jbsp_pkg::TLR : jbsp_pkg::RTI;
         jbsp_pkg::RTI: tap_d = tms ? jbsp_pkg::SEL_DR : jbsp_pkg::RTI;
         jbsp_pkg::SEL_DR: tap_d = tms ? jbsp_pkg::SEL_IR : jbsp_pkg::CAP_DR;
         jbsp_pkg::CAP_DR: tap_d = tms ? jbsp_pkg::EX1_DR : jbsp_pkg::SH_DR;
         jbsp_pkg::SH_DR: tap_d = tms ? jbsp_pkg::EX1_DR : jbsp_pkg::SH_DR;
         jbsp_pkg::EX1_DR: tap_d = tms ? jbsp_pkg::UPD_DR : jbsp_pkg::PAU_DR;
         jbsp_pkg::PAU_DR: tap_d = tms ? jbsp_pkg::EX2_DR : jbsp_pkg::PAU_DR;
         jbsp_pkg::EX2_DR: tap_d = tms ? jbsp_pkg::UPD_DR : jbsp_pkg::SH_DR;
         jbsp_pkg::UPD_DR: tap_d = tms ? jbsp_pkg::SEL_DR : jbsp_pkg::RTI;
         jbsp_pkg::SEL_IR: tap_d = tms ? jbsp_pkg::TLR : jbsp_pkg::CAP_IR;
         jbsp_pkg::CAP_IR: tap_d = tms ? jbsp_pkg::EX1_IR : jbsp_pkg::SH_IR;
         jbsp_pkg::SH_IR: tap_d = tms ? jbsp_pkg::EX1_IR : jbsp_pkg::SH_IR;
         jbsp_pkg::EX1_IR: tap_d = tms ? jbsp_pkg::UPD_IR : jbsp_pkg::PAU_IR;
         jbsp_pkg::PAU_IR: tap_d = tms ? jbsp_pkg::EX2_IR : jbsp_pkg::PAU_IR;
         jbsp_pkg::EX2_IR: tap_d = tms ? jbsp_pkg::UPD_IR : jbsp_pkg::SH_IR;
         jbsp_pkg::UPD_IR: tap_d = tms ? jbsp_pkg::SEL_DR : jbsp_pkg::RTI;
         default: tap_d = jbsp_pkg::TLR;
      endcase
   end

   // Reset at power-up; a disabled port stays in reset
   always_ff @(posedge CLK)
   begin
      if (RST || !jtag_en_q)
         tap_q <= jbsp_pkg::TLR;
      else if (tck_rise)
         tap_q <= tap_d;
   end

   // ****************************************
   // Instruction register
   // ****************************************
   jbsp_pkg::jbsp_ir_t ir_sh_q, ir_q;

   function automatic jbsp_pkg::jbsp_ir_t ir_legal(jbsp_pkg::jbsp_ir_t c);
      case (c)
         `JBSP_IR_EXTEST, `JBSP_IR_SAMPLE, `JBSP_IR_IDCODE, `JBSP_IR_HIGHZ:
            ir_legal = c;
         default: ir_legal = `JBSP_IR_BYPASS;
      endcase
   endfunction : ir_legal

   function automatic logic sel_bs(jbsp_pkg::jbsp_ir_t c);
      sel_bs = (c == `JBSP_IR_EXTEST) || (c == `JBSP_IR_SAMPLE);
   endfunction : sel_bs

   always_ff @(posedge CLK)
   begin
      if (RST || tap_q == jbsp_pkg::TLR)
      begin
         ir_sh_q <= `JBSP_IR_CAPT;
         ir_q <= `JBSP_IR_IDCODE;
      end
      else if (tck_rise)
      begin
         if (tap_q == jbsp_pkg::CAP_IR)
            ir_sh_q <= `JBSP_IR_CAPT;
         else if (tap_q == jbsp_pkg::SH_IR)
            ir_sh_q <= {tdi, ir_sh_q[`JBSP_IR_LEN-1:1]};
         else if (tap_q == jbsp_pkg::UPD_IR)
            ir_q <= ir_legal(ir_sh_q);
      end
   end

   // ****************************************
   // Data registers and scan chain
   // ****************************************
   logic cap_dr, sh_dr, upd_bs;
   logic byp_q;
   logic [31:0] id_q;
   logic [NCH:0] chain;
   logic [1:0] upd_v [`JBSP_NIO];

   assign cap_dr = tck_rise && tap_q == jbsp_pkg::CAP_DR;
   assign sh_dr = tck_rise && tap_q == jbsp_pkg::SH_DR;
   assign upd_bs = tck_rise && tap_q == jbsp_pkg::UPD_DR && sel_bs(ir_q);

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         byp_q <= 1'b0;
         id_q <= `JBSP_IDCODE;
      end
      else if (cap_dr)
      begin
         byp_q <= 1'b0;
         id_q <= `JBSP_IDCODE;
      end
      else if (sh_dr)
      begin
         byp_q <= tdi;
         id_q <= {tdi, id_q[31:1]};
      end
   end

   assign chain[0] = tdi;
   genvar g;
   generate
      for (g = 0; g < `JBSP_NIO; g++)
      begin : g_io
         jbsp_scan_cell #(.NCAP(`JBSP_CAP_IO), .NUPD(`JBSP_UPD_IO)) u_cell (
            .clk(CLK),
            .rst(RST),
            .capture(cap_dr && sel_bs(ir_q)),
            .shift(sh_dr && sel_bs(ir_q)),
            .update(upd_bs),
            .par_in({CORE_OE[g], CORE_O[g], pin_s2_q[g]}),
            .si(chain[g]),
            .so(chain[g+1]),
            .upd_out(upd_v[g])
         );
      end
      for (g = 0; g < `JBSP_NDIN + `JBSP_NMC; g++)
      begin : g_in
         logic src;
         if (g < `JBSP_NDIN)
         begin : g_din
            assign src = din_s2_q[g];
         end
         else
         begin : g_mc
            assign src = MC_I[g-`JBSP_NDIN];
         end
         jbsp_scan_cell #(.NCAP(`JBSP_CAP_IN), .NUPD(0)) u_cell (
            .clk(CLK),
            .rst(RST),
            .capture(cap_dr && sel_bs(ir_q)),
            .shift(sh_dr && sel_bs(ir_q)),
            .update(1'b0),
            .par_in({2'h0, src}),
            .si(chain[`JBSP_NIO+g]),
            .so(chain[`JBSP_NIO+g+1]),
            .upd_out()
         );
      end
   endgenerate

   // ****************************************
   // Test data output on falling test clock
   // ****************************************
   logic tdo_q, tdo_oe_q, dr_bit;

   always_comb
   begin
      if (sel_bs(ir_q))
         dr_bit = chain[NCH];
      else if (ir_q == `JBSP_IR_IDCODE)
         dr_bit = id_q[0];
      else
         dr_bit = byp_q;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo_q <= (tap_q == jbsp_pkg::SH_IR) ? ir_sh_q[0] : dr_bit;
         tdo_oe_q <= tap_q == jbsp_pkg::SH_IR || tap_q == jbsp_pkg::SH_DR;
      end
   end

   // Index 3 is the data output; the others are inputs while enabled
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         JPIN_O <= 4'h0;
         JPIN_OE <= 4'h0;
         PULLUP_ON <= 1'b0;
      end
      else
      begin
         JPIN_O <= jtag_en_q ? {tdo_q, 3'h0} : USR_JPIN_O;
         JPIN_OE <= jtag_en_q ? {tdo_oe_q, 3'h0} : USR_JPIN_OE;
         PULLUP_ON <= jtag_en_q && PULLUP_EN;
      end
   end

   // ****************************************
   // Configuration state and pin protection
   // ****************************************
   jbsp_pkg::jbsp_cfg_e cfg_q;
   logic [`JBSP_NIO-1:0] last_q, ext_o, ext_oe;

   always_ff @(posedge CLK)
   begin
      if (RST)
         cfg_q <= jbsp_pkg::CFG_ERASED;
      else if (PROG_START)
         cfg_q <= jbsp_pkg::CFG_PROG;
      else if (cfg_q == jbsp_pkg::CFG_PROG)
      begin
         if (PROG_ABORT || tap_q == jbsp_pkg::TLR)
            cfg_q <= jbsp_pkg::CFG_LOCKED;
         else if (PROG_DONE)
            cfg_q <= jbsp_pkg::CFG_VALID;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         last_q <= '0;
      else if (cfg_q != jbsp_pkg::CFG_PROG)
         last_q <= (PIN_OE & PIN_O) | (~PIN_OE & pin_s2_q);
   end

   always_comb
   begin
      for (int i = 0; i < `JBSP_NIO; i++)
      begin
         ext_o[i] = upd_v[i][0];
         ext_oe[i] = upd_v[i][1];
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         PIN_O <= '0;
         PIN_OE <= '0;
         CFG_VALID <= 1'b0;
      end
      else
      begin
         CFG_VALID <= cfg_q == jbsp_pkg::CFG_VALID;
         if (cfg_q == jbsp_pkg::CFG_PROG)
         begin
            PIN_O <= last_q;
            PIN_OE <= KEEPER_EN ? '1 : '0;
         end
         else if (cfg_q != jbsp_pkg::CFG_VALID)
         begin
            PIN_O <= '0;
            PIN_OE <= '0;
         end
         else if (ir_q == `JBSP_IR_HIGHZ)
         begin
            PIN_O <= '0;
            PIN_OE <= '0;
         end
         else if (ir_q == `JBSP_IR_EXTEST)
         begin
            PIN_O <= ext_o;
            PIN_OE <= ext_oe;
         end
         else
         begin
            PIN_O <= CORE_O;
            PIN_OE <= CORE_OE;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   lock_hiz_a: assert property (@(posedge CLK) disable iff (RST)
      cfg_q == jbsp_pkg::CFG_LOCKED |=> PIN_OE == '0)
      else $error("locked device drives a pin");
   abort_lock_a: assert property (@(posedge CLK) disable iff (RST)
      cfg_q == jbsp_pkg::CFG_PROG && PROG_ABORT && !PROG_START
      |=> cfg_q == jbsp_pkg::CFG_LOCKED ##1 PIN_OE == '0)
      else $error("abort did not lock pins");
   keeper_hold_a: assert property (@(posedge CLK) disable iff (RST)
      cfg_q == jbsp_pkg::CFG_PROG && KEEPER_EN
      |=> PIN_OE == '1 && PIN_O == $past(last_q))
      else $error("keeper did not hold pin level");
   erased_prog_a: assert property (@(posedge CLK) disable iff (RST)
      cfg_q == jbsp_pkg::CFG_ERASED && PROG_START
      |=> cfg_q == jbsp_pkg::CFG_PROG)
      else $error("erased device refused programming");
   power_reset_a: assert property (@(posedge CLK) disable iff (RST)
      $past(RST) |-> tap_q == jbsp_pkg::TLR && ir_q == `JBSP_IR_IDCODE)
      else $error("TAP not reset after power-up");
   bad_code_a: assert property (@(posedge CLK) disable iff (RST)
      tck_rise && tap_q == jbsp_pkg::UPD_IR && ir_sh_q == 4'h7
      |=> ir_q == `JBSP_IR_BYPASS)
      else $error("unknown code not mapped to bypass");
   highz_pins_a: assert property (@(posedge CLK) disable iff (RST)
      ir_q == `JBSP_IR_HIGHZ && cfg_q == jbsp_pkg::CFG_VALID |=> PIN_OE == '0)
      else $error("highz left a pin driven");
   extest_drive_a: assert property (@(posedge CLK) disable iff (RST)
      ir_q == `JBSP_IR_EXTEST && cfg_q == jbsp_pkg::CFG_VALID
      |=> PIN_OE == $past(ext_oe) && PIN_O == $past(ext_o))
      else $error("extest pins differ from update stages");
   port_off_a: assert property (@(posedge CLK) disable iff (RST)
      !jtag_en_q |=> JPIN_OE == $past(USR_JPIN_OE) && tap_q == jbsp_pkg::TLR)
      else $error("disabled port still owns its pins");
   bypass_tdo_a: assert property (@(posedge CLK) disable iff (RST)
      jtag_en_q && tck_fall && tap_q == jbsp_pkg::SH_DR
      && ir_q == `JBSP_IR_BYPASS |=> ##1 JPIN_O[3] == $past(byp_q, 2))
      else $error("bypass bit not on data output");
endmodule : jbsp_top

// [verification/jbsp_tester.sv]
// Test-port tester model: drives the test clock, mode and data pins
`timescale 1ns/1ns
module jbsp_tester (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe
);
   logic last_q;
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      last_q = 1'b0;
   end
   // ****************************************
   // Test clock steps; TDO taken at the fall
   // ****************************************
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #200 tck = 1'b1;
      // Spoil data after the rise so a late sample shows up as a mismatch
      #100 tdi = ~d;
      #100 o = tdo_oe ? tdo : ~last_q;
      last_q = o;
      tck = 1'b0;
   endtask : step
   task automatic reset_tap();
      logic o;
      #13;
      repeat (5) step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
   endtask : reset_tap
   // From idle through one scan of n bits, LSB first, and back to idle
   task automatic scan(input logic ir, input int n,
                       input logic [131:0] din, output logic [131:0] dout);
      logic o;
      #13;
      dout = '0;
      step(1'b1, 1'b0, o);
      if (ir)
         step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], dout[i]);
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask : scan
endmodule : jbsp_tester

// [verification/jbsp_top_tb.sv]
// Self-checking bench of the boundary-scan and programming port
`timescale 1ns/1ns
`include "jbsp_defs.svh"
module jbsp_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tck, tms, tdi;
   logic jtag_en = 1'b1;
   logic pullup_en = 1'b1;
   logic keeper_en = 1'b0;
   logic prog_start = 1'b0;
   logic prog_done = 1'b0;
   logic prog_abort = 1'b0;
   logic [31:0] pin_i = '0;
   logic [3:0] din_i = '0;
   logic [31:0] core_o = '0;
   logic [31:0] core_oe = '0;
   logic [31:0] mc_i = '0;
   logic [3:0] usr_jpin_o = '0;
   logic [3:0] usr_jpin_oe = '0;
   logic [31:0] pin_o, pin_oe, exp_o, exp_oe;
   logic [3:0] jpin_o, jpin_oe;
   logic pullup_on, cfg_valid, v;
   logic [131:0] din, dout, expv;
   logic q[$];
   logic [3:0] codes [4] = '{4'hf, 4'h3, 4'h7, 4'hc};
   int error_cnt = 0;
   int check_count = 0;

   always #25 clk = ~clk;

   jbsp_top jbsp_top_inst (.CLK(clk), .RST(rst), .TCK_I(tck), .TMS_I(tms),
      .TDI_I(tdi), .JTAG_EN(jtag_en), .PULLUP_EN(pullup_en),
      .KEEPER_EN(keeper_en), .PROG_START(prog_start), .PROG_DONE(prog_done),
      .PROG_ABORT(prog_abort), .PIN_I(pin_i), .DIN_I(din_i), .CORE_O(core_o),
      .CORE_OE(core_oe), .MC_I(mc_i), .USR_JPIN_O(usr_jpin_o),
      .USR_JPIN_OE(usr_jpin_oe), .PIN_O(pin_o), .PIN_OE(pin_oe),
      .JPIN_O(jpin_o), .JPIN_OE(jpin_oe), .PULLUP_ON(pullup_on),
      .CFG_VALID(cfg_valid));

   jbsp_tester jbsp_tester_inst (.tck(tck), .tms(tms), .tdi(tdi),
      .tdo(jpin_o[3]), .tdo_oe(jpin_oe[3]));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input logic [131:0] seen, input logic [131:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : wait_clk
   // Pulse 0 starts, 1 completes, 2 aborts programming
   task automatic pulse(input int k);
      @(posedge clk);
      prog_start <= (k == 0);
      prog_done <= (k == 1);
      prog_abort <= (k == 2);
      @(posedge clk);
      prog_start <= 1'b0;
      prog_done <= 1'b0;
      prog_abort <= 1'b0;
      wait_clk(4);
   endtask : pulse
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      void'($urandom(68));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wait_clk(4);
      check(cfg_valid, 1'b0);
      check(pin_oe, '0);
      check(jpin_oe, 4'h0);
      check(pullup_on, 1'b1);
      $display("Test reset done");
      @(posedge clk);
      jtag_en <= 1'b0;
      usr_jpin_o <= 4'($urandom);
      usr_jpin_oe <= 4'($urandom);
      wait_clk(4);
      check(jpin_o, usr_jpin_o);
      check(jpin_oe, usr_jpin_oe);
      check(pullup_on, 1'b0);
      @(posedge clk);
      jtag_en <= 1'b1;
      wait_clk(4);
      $display("Test disabled port done");
      jbsp_tester_inst.reset_tap();
      jbsp_tester_inst.scan(1'b0, 32, '0, dout);
      check(dout[31:0], `JBSP_IDCODE);
      check(jpin_oe, 4'h0);
      $display("Test identification done");
      foreach (codes[k])
      begin
         jbsp_tester_inst.scan(1'b1, 4, codes[k], dout);
         check(dout[3:0], 4'h1);
         for (int i = 0; i < 132; i++)
            din[i] = 1'($urandom);
         jbsp_tester_inst.scan(1'b0, 9, din, dout);
         q = {1'b0};
         for (int i = 0; i < 9; i++)
         begin
            q.push_back(din[i]);
            expv[i] = q.pop_front();
         end
         check(dout[8:0], expv[8:0]);
      end
      $display("Test instruction table done");
      @(posedge clk);
      core_o <= $urandom;
      core_oe <= $urandom;
      pin_i <= $urandom;
      din_i <= 4'($urandom);
      mc_i <= $urandom;
      pulse(0);
      check(cfg_valid, 1'b0);
      pulse(1);
      check(cfg_valid, 1'b1);
      check(pin_oe, core_oe);
      check(pin_o & core_oe, core_o & core_oe);
      @(posedge clk);
      keeper_en <= 1'b1;
      pulse(0);
      check(pin_oe, 32'hffff_ffff);
      check(pin_o, (core_o & core_oe) | (pin_i & ~core_oe));
      pulse(2);
      check(cfg_valid, 1'b0);
      check(pin_oe, '0);
      pulse(1);
      check(cfg_valid, 1'b0);
      pulse(0);
      jbsp_tester_inst.reset_tap();
      pulse(1);
      check(cfg_valid, 1'b0);
      pulse(0);
      pulse(1);
      check(cfg_valid, 1'b1);
      $display("Test programming done");
      jbsp_tester_inst.scan(1'b1, 4, 4'h1, dout);
      for (int p = 0; p < 132; p++)
      begin
         v = p < 96 ? (p % 3 == 0 ? pin_i[p / 3] : p % 3 == 1 ?
             core_o[p / 3] : core_oe[p / 3]) : p < 100 ? din_i[p - 96] :
             mc_i[p - 100];
         expv[131 - p] = v;
         din[131 - p] = 1'($urandom);
      end
      jbsp_tester_inst.scan(1'b0, 132, din, dout);
      check(dout, expv);
      for (int k = 0; k < 32; k++)
      begin
         exp_o[k] = din[130 - 3 * k];
         exp_oe[k] = din[129 - 3 * k];
      end
      jbsp_tester_inst.scan(1'b1, 4, 4'h0, dout);
      wait_clk(2);
      check(pin_o, exp_o);
      check(pin_oe, exp_oe);
      jbsp_tester_inst.scan(1'b1, 4, 4'h3, dout);
      wait_clk(2);
      check(pin_oe, '0);
      $display("Test boundary chain done");
      complete_run();
   end

   // About eight times the expected length of the run
   initial
   begin
      #1_000_000;
      error_cnt++;
      complete_run();
   end
endmodule : jbsp_top_tb
